// ===== core/apgp_defines.svh
// Register offsets, field widths and reset values of the GPIO port.
// Included by the package and the port module; definitions only.
`ifndef APGP_DEFINES_SVH
`define APGP_DEFINES_SVH
`define APGP_PIN_COUNT 8
`define APGP_ADDR_W 12
`define APGP_OFF_CONNECT 12'h000
`define APGP_OFF_DIRECTION 12'h004
`define APGP_OFF_LEVEL 12'h008
`define APGP_RST_CONNECT 8'h00
`define APGP_RST_DIRECTION 8'hFF
`define APGP_RST_LEVEL 8'h00
`endif

// ===== core/apgp_pkg.sv
// Types used by the GPIO port; its bench does not use them.
// Assumes apgp_defines.svh is on the include path.
`include "apgp_defines.svh"
package apgp_pkg;
  typedef logic [`APGP_PIN_COUNT-1:0] apgp_pins_t;
  typedef struct packed {
    logic [`APGP_ADDR_W-1:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } apgp_req_t;
  typedef enum logic [1:0] {
    APGP_REG_CONNECT,
    APGP_REG_DIRECTION,
    APGP_REG_LEVEL,
    APGP_REG_NONE
  } apgp_reg_sel_t;
endpackage

// ===== core/apgp_port.sv
// Eight-pin digital port sharing analog input pins, APB register access.
// Assumes one clock; pin inputs are asynchronous and synchronised here.
//
// Contract
// - Eight analog pins, common input down to input three, form port bits 0-7.
// - Connect bit 1 attaches the pin to digital I/O, else stays analog.
// - Direction bit 0 drives an output, 1 makes the pin an input.
// - Data register drives output levels and reads back sampled input levels.
// - Data bits of output pins read back as zero.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "apgp_defines.svh"
module apgp_port (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`APGP_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Port pins, bit 0 is the lowest usable analog input
  input wire logic [`APGP_PIN_COUNT-1:0] pin_in_i,
  output logic [`APGP_PIN_COUNT-1:0] pin_out_o,
  output logic [`APGP_PIN_COUNT-1:0] pin_oe_o,
  output logic [`APGP_PIN_COUNT-1:0] pin_digital_o
);

  apgp_pkg::apgp_pins_t pin_connect_select_r;
  apgp_pkg::apgp_pins_t pin_direction_select_r;
  apgp_pkg::apgp_pins_t pin_level_value_r;
  apgp_pkg::apgp_pins_t pin_sync1_r;
  apgp_pkg::apgp_pins_t pin_sync2_r;
  apgp_pkg::apgp_pins_t level_read_nxt;
  apgp_pkg::apgp_reg_sel_t sel;
  logic access;
  logic wr_en;
  logic rd_en;
  logic [31:0] rdata_nxt;

  function automatic apgp_pkg::apgp_reg_sel_t decode(
    input logic [`APGP_ADDR_W-1:0] addr
  );
    case (addr)
      `APGP_OFF_CONNECT: decode = apgp_pkg::APGP_REG_CONNECT;
      `APGP_OFF_DIRECTION: decode = apgp_pkg::APGP_REG_DIRECTION;
      `APGP_OFF_LEVEL: decode = apgp_pkg::APGP_REG_LEVEL;
      default: decode = apgp_pkg::APGP_REG_NONE;
    endcase
  endfunction

  // Zero-wait slave: every access phase completes in its first cycle
  assign access = psel_i && penable_i && clk_en_i;
  assign wr_en = access && pwrite_i;
  assign rd_en = access && !pwrite_i;
  assign sel = decode(paddr_i);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && (sel == apgp_pkg::APGP_REG_NONE);

  // Two-stage synchroniser on the pin inputs
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_sync1_r <= 8'h00;
      pin_sync2_r <= 8'h00;
    end else if (clk_en_i) begin
      pin_sync1_r <= pin_in_i;
      pin_sync2_r <= pin_sync1_r;
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_connect_select_r <= `APGP_RST_CONNECT;
      pin_direction_select_r <= `APGP_RST_DIRECTION;
    end else if (wr_en) begin
      if (sel == apgp_pkg::APGP_REG_CONNECT) begin
        pin_connect_select_r <= pwdata_i[7:0];
      end
      if (sel == apgp_pkg::APGP_REG_DIRECTION) begin
        pin_direction_select_r <= pwdata_i[7:0];
      end
    end
  end

  // Output level latch; held while a pin is input so it is ready on turnaround
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_level_value_r <= `APGP_RST_LEVEL;
    end else if (wr_en && sel == apgp_pkg::APGP_REG_LEVEL) begin
      pin_level_value_r <= pwdata_i[7:0];
    end
  end

  // Pin drive registered so the pads never glitch
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_out_o <= 8'h00;
      pin_oe_o <= 8'h00;
      pin_digital_o <= 8'h00;
    end else if (clk_en_i) begin
      pin_digital_o <= pin_connect_select_r;
      pin_oe_o <= pin_connect_select_r & ~pin_direction_select_r;
      pin_out_o <= pin_level_value_r & pin_connect_select_r;
    end
  end

  // Input pins return sampled level; output pins read zero
  always_comb begin
    level_read_nxt = pin_sync2_r & pin_direction_select_r;
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (sel)
      apgp_pkg::APGP_REG_CONNECT: rdata_nxt[7:0] = pin_connect_select_r;
      apgp_pkg::APGP_REG_DIRECTION: rdata_nxt[7:0] = pin_direction_select_r;
      apgp_pkg::APGP_REG_LEVEL: rdata_nxt[7:0] = level_read_nxt;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read data captured in setup phase, valid during the access cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (clk_en_i && psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= rdata_nxt;
    end
  end

endmodule // apgp_port

// ===== dv/apgp_port_assertions.sv
// Checks on the bus and pins of apgp_port.
// Bound from the bench top; one clock.
`timescale 1ns/1ps
module apgp_chk (
  // Bus
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  // Pins
  input wire logic [7:0] pin_out_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] pin_digital_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic acc;
  assign acc = psel_i && penable_i;
  AST_OE: assert property (
    (pin_oe_o & ~pin_digital_o) == 8'h00) else $error("oe");
  AST_OUT: assert property (
    (pin_out_o & ~pin_digital_o) == 8'h00) else $error("out");
  AST_MAP: assert property (acc |-> pslverr_o ==
    !(paddr_i inside {12'h000, 12'h004, 12'h008})) else $error("map");
  AST_LVL: assert property (acc && clk_en_i && !pwrite_i &&
    paddr_i == 12'h008
    |-> (prdata_o & {24'hFFFFFF, pin_oe_o}) == 0) else $error("lvl");
  AST_CON: assert property (acc && clk_en_i && pwrite_i &&
    paddr_i == 12'h000
    |=> ##1 pin_digital_o == $past(pwdata_i[7:0], 2)) else $error("con");
  AST_DAT: assert property (acc && clk_en_i && pwrite_i &&
    paddr_i == 12'h008
    |=> ##1 pin_out_o == ($past(pwdata_i[7:0], 2) & pin_digital_o))
    else $error("dat");
  cover property (acc && pwrite_i && paddr_i == 12'h004);
  cover property (acc && pslverr_o);
  cover property (pin_oe_o != 8'h00);
endmodule // apgp_chk

// ===== dv/apgp_pad_model.sv
// External drivers on the shared pins.
// Device-driven bits override the outside level.
`timescale 1ns/1ps
module apgp_pad_model (
  // Device and bench sides
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] pin_in_o
);
  assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_i);
endmodule // apgp_pad_model

// ===== dv/apgp_port_tb.sv
// Random register traffic against an integer model.
// Clock enable dropped at random during writes, else high; pads from the pad model.
`timescale 1ns/1ps
module apgp_port_tb;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, rdy, serr;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h00000000, prd, r, d;
  logic [7:0] pout, poe, pdig, pin, drv = 8'h00;
  logic en = 1'b1, e, s;
  int err_count = 0, samples_checked = 0, cyc = 0, a;
  int m[3] = '{0, 255, 0};
  apgp_port i_apgp_port(.sys_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(en),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
    .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(serr),
    .pin_in_i(pin), .pin_out_o(pout), .pin_oe_o(poe), .pin_digital_o(pdig));
  apgp_pad_model i_apgp_pad_model(.pin_out_i(pout), .pin_oe_i(poe),
    .ext_i(drv), .pin_in_o(pin));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input int ad, input logic [31:0] dv);
    psel <= 1'b1;
    pwr <= w;
    pa <= 12'(ad);
    pwd <= dv;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    r = prd;
    s = serr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic scan;
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, k * 4, 32'h00000000);
      chk(r, k == 3 ? 0 : k == 2 ? drv & m[1] : m[k]);
      chk(32'(s), 32'(k == 3));
    end
    chk({pdig, poe, pout},
      {8'(m[0]), 8'(m[0] & ~m[1]), 8'(m[2] & m[0])});
  endtask
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(47208));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    scan();
    repeat (80) begin
      a = $urandom % 4;
      d = $urandom;
      drv <= 8'($urandom);
      e = ($urandom % 4) != 0;
      en <= e;
      apb(1'b1, a * 4, d);
      en <= 1'b1;
      if (a < 3 && e) m[a] = d[7:0];
      scan();
    end
    wrap_up();
  end
endmodule // apgp_port_tb
bind apgp_port apgp_chk i_apgp_chk(.*);
